// >>> pkg/hdgo_pkg.sv
// constants for the hall gain, offset and clamp conditioning path
`default_nettype none
package hdgo_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_RANGE   = 8'h00;
  localparam logic [7:0] OFF_GAIN    = 8'h04;
  localparam logic [7:0] OFF_OFFSET  = 8'h08;
  localparam logic [7:0] OFF_FILTER  = 8'h0c;
  localparam logic [7:0] OFF_CLAMP   = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_RESULT  = 8'h18;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h24;
  // clamp register field positions
  localparam int CEIL_LSB = 8;
  // values after reset
  localparam logic [1:0]  RST_RANGE  = 2'h1;
  localparam logic [14:0] RST_GAIN   = 15'h5000;
  localparam logic [14:0] RST_OFFSET = 15'h4000;
  localparam logic [2:0]  RST_FILTER = 3'h7;
  localparam logic [5:0]  RST_FLOOR  = 6'h00;
  localparam logic [5:0]  RST_CEIL   = 6'h3f;
  // code decoding constants
  localparam logic [1:0]  RANGE_UNUSED = 2'h2;
  localparam logic [1:0]  RANGE_MID    = 2'h1;
  localparam logic [15:0] CODE_BIAS    = 16'h4000;
  localparam int          GAIN_FRAC    = 12;
  localparam logic [2:0]  FILTER_OFF   = 3'h7;
  localparam logic [5:0]  FLOOR_OFF    = 6'h00;
  localparam logic [5:0]  CEIL_OFF     = 6'h3f;
  // sample update timing
  localparam int CLK_HZ    = 40_000_000;
  localparam int UPDATE_HZ = 16_000;
  localparam int TICK_CYC  = CLK_HZ / UPDATE_HZ;
  // event bit positions
  localparam int EV_SAMPLE = 0;
  localparam int EV_OVER   = 1;
  localparam int EV_CORR   = 2;
  localparam int EV_DEFECT = 3;
endpackage
`default_nettype wire

// >>> verilog/hdgo_core.sv
// hall sample filter, gain, offset, limiter, clamp and diagnostics
//
// Summary of operation
// [RQ1] range code 3/1/0 gives 50/100/200 mT
// [RQ2] unused range code 2 acts as 1
// [RQ3] gain factor is (code - 16384) / 4096
// [RQ4] filtered sample multiplied by gain first
// [RQ5] add offset code minus 16384, 1-LSB steps
// [RQ6] 3-bit filter select, code 7 bypasses
// [RQ7] filter has unity dc gain always
// [RQ8] new filtered samples at 16 kHz
// [RQ9] floor = code*64*16, zero disables it
// [RQ10] ceiling = (code+1)*1024-1, 63 disables
// [RQ11] out-of-window output replaced by nearer limit
// [RQ12] floor above ceiling: ceiling wins
// [RQ13] software keeps floor below ceiling
// [RQ14] software sets range before calibrating
// [RQ15] errors reported in output status nibble
// [RQ16] overvoltage sets flag, driver held off
// [RQ17] correct first bit error, detect second
// [RQ18] uncorrectable error turns driver off forever
// [RQ19] offset sum limited to 16 bits
`timescale 1ns/1ps
`default_nettype none
module hdgo_core (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  // hall converter side
  input  wire logic [15:0] adc_sample,
  output logic      [1:0]  adc_range_ff,
  // diagnostics inputs
  input  wire logic        ov_detect,
  input  wire logic        mem_err_valid,
  input  wire logic [3:0]  mem_err_line,
  // toward protocol generation
  output logic      [15:0] out_value_ff,
  output logic             out_valid_ff,
  output logic      [3:0]  out_status_ff,
  output logic             drv_oe_n_ff,
  // interrupt
  output logic             irq_ff
);
  logic [1:0]         range_ff;
  logic [14:0]        gain_ff;
  logic [14:0]        offs_ff;
  logic [2:0]         filt_sel_ff;
  logic [5:0]         floor_ff;
  logic [5:0]         ceil_ff;
  logic [3:0]         irq_stat_ff;
  logic [3:0]         irq_en_ff;
  logic [11:0]        cnt_ff;
  logic               tick_ff;
  logic signed [23:0] acc_ff;
  logic               v1_ff;
  logic signed [19:0] prod_ff;
  logic               v2_ff;
  logic [15:0]        lim_ff;
  logic               v3_ff;
  logic               ov_ff;
  logic               corr_ff;
  logic [3:0]         corr_line_ff;
  logic               defect_ff;
  logic               clamped_ff;
  logic [31:0]        nxt_prdata;
  logic               nxt_err;
  logic [3:0]         nxt_ev;
  logic [15:0]        nxt_out;
  logic               nxt_clamped;
  logic signed [15:0] filt;
  logic signed [15:0] gain_s;
  logic signed [15:0] offs_s;
  logic signed [31:0] product;
  logic signed [20:0] sum;
  logic signed [24:0] diff;
  logic [2:0]         shift;
  logic [15:0]        floor_v;
  logic [15:0]        ceil_v;
  logic               setup;
  logic               wr;

  // apb phase decode
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready_ff & pwrite;

  // read mux and unmapped-address detection
  always_comb begin
    nxt_prdata = 32'h0;
    nxt_err    = 1'b0;
    case (paddr)
      hdgo_pkg::OFF_RANGE:   nxt_prdata[1:0]  = range_ff;
      hdgo_pkg::OFF_GAIN:    nxt_prdata[14:0] = gain_ff;
      hdgo_pkg::OFF_OFFSET:  nxt_prdata[14:0] = offs_ff;
      hdgo_pkg::OFF_FILTER:  nxt_prdata[2:0]  = filt_sel_ff;
      hdgo_pkg::OFF_CLAMP: begin
        nxt_prdata[5:0] = floor_ff;
        nxt_prdata[hdgo_pkg::CEIL_LSB +: 6] = ceil_ff;
      end
      hdgo_pkg::OFF_STATUS:
        nxt_prdata[5:0] = {adc_range_ff, clamped_ff, corr_ff,
                           defect_ff, ov_ff};
      hdgo_pkg::OFF_RESULT:  nxt_prdata[15:0] = out_value_ff;
      hdgo_pkg::OFF_IRQ_ST:  nxt_prdata[3:0]  = irq_stat_ff;
      hdgo_pkg::OFF_IRQ_CLR: nxt_prdata       = 32'h0;
      hdgo_pkg::OFF_IRQ_EN:  nxt_prdata[3:0]  = irq_en_ff;
      default:               nxt_err          = 1'b1;
    endcase
  end

  // zero-wait-state answer: data and ready set in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_err;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
      end
    end
  end

  // configuration registers written by software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      range_ff    <= hdgo_pkg::RST_RANGE;
      gain_ff     <= hdgo_pkg::RST_GAIN;
      offs_ff     <= hdgo_pkg::RST_OFFSET;
      filt_sel_ff <= hdgo_pkg::RST_FILTER;
      floor_ff    <= hdgo_pkg::RST_FLOOR;
      ceil_ff     <= hdgo_pkg::RST_CEIL;
      irq_en_ff   <= 4'h0;
    end else if (wr) begin
      case (paddr)
        hdgo_pkg::OFF_RANGE:  range_ff    <= pwdata[1:0];
        hdgo_pkg::OFF_GAIN:   gain_ff     <= pwdata[14:0];
        hdgo_pkg::OFF_OFFSET: offs_ff     <= pwdata[14:0];
        hdgo_pkg::OFF_FILTER: filt_sel_ff <= pwdata[2:0];
        hdgo_pkg::OFF_CLAMP: begin
          floor_ff <= pwdata[5:0];
          ceil_ff  <= pwdata[hdgo_pkg::CEIL_LSB +: 6];
        end
        hdgo_pkg::OFF_IRQ_EN: irq_en_ff   <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // range code to converter, unused code folded onto mid range
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_range_ff <= hdgo_pkg::RST_RANGE;
    end else if (range_ff == hdgo_pkg::RANGE_UNUSED) begin
      adc_range_ff <= hdgo_pkg::RANGE_MID; // RQ2
    end else begin
      adc_range_ff <= range_ff; // RQ1
    end
  end

  // update-rate divider, one tick per sample period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 12'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (cnt_ff == 12'(hdgo_pkg::TICK_CYC - 1)); // RQ8
      if (cnt_ff == 12'(hdgo_pkg::TICK_CYC - 1)) begin
        cnt_ff <= 12'h0;
      end else begin
        cnt_ff <= cnt_ff + 12'h1;
      end
    end
  end

  // first-order low-pass; y += (x - y) >> k keeps dc gain at one
  assign shift = hdgo_pkg::FILTER_OFF - filt_sel_ff;
  assign diff  = {adc_sample[15], adc_sample, 8'h0} - 25'(acc_ff);
  assign filt  = acc_ff[23:8];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 24'sh0;
      v1_ff  <= 1'b0;
    end else begin
      v1_ff <= tick_ff; // RQ8
      if (tick_ff) begin
        if (filt_sel_ff == hdgo_pkg::FILTER_OFF) begin
          acc_ff <= {adc_sample, 8'h0}; // RQ6
        end else begin
          acc_ff <= acc_ff + 24'(diff >>> shift); // RQ6 RQ7
        end
      end
    end
  end

  // gain stage: signed factor with 12 fraction bits
  assign gain_s  = $signed({1'b0, gain_ff}) - $signed(hdgo_pkg::CODE_BIAS);
  assign product = filt * gain_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prod_ff <= 20'sh0;
      v2_ff   <= 1'b0;
    end else begin
      v2_ff <= v1_ff;
      if (v1_ff) begin
        prod_ff <= product[31:hdgo_pkg::GAIN_FRAC]; // RQ3 RQ4
      end
    end
  end

  // offset addition and limiting to the 16-bit output span
  assign offs_s = $signed({1'b0, offs_ff}) - $signed(hdgo_pkg::CODE_BIAS);
  assign sum    = 21'(prod_ff) + 21'(offs_s); // RQ5

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_ff <= 16'h0;
      v3_ff  <= 1'b0;
    end else begin
      v3_ff <= v2_ff;
      if (v2_ff) begin
        if (sum < 0) begin
          lim_ff <= 16'h0; // RQ19
        end else if (sum > 21'sh0ffff) begin
          lim_ff <= 16'hffff; // RQ19
        end else begin
          lim_ff <= sum[15:0];
        end
      end
    end
  end

  // clamp window; ceiling applied last so it dominates
  assign floor_v = {floor_ff, 10'h000}; // RQ9
  assign ceil_v  = {ceil_ff, 10'h3ff}; // RQ10

  always_comb begin
    nxt_out     = lim_ff;
    nxt_clamped = 1'b0;
    if (floor_ff != hdgo_pkg::FLOOR_OFF && nxt_out < floor_v) begin
      nxt_out     = floor_v; // RQ9 RQ11
      nxt_clamped = 1'b1;
    end
    if (ceil_ff != hdgo_pkg::CEIL_OFF && nxt_out > ceil_v) begin
      nxt_out     = ceil_v; // RQ10 RQ11 RQ12
      nxt_clamped = 1'b1;
    end
  end

  // result register and status nibble toward the protocol stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_value_ff  <= 16'h0;
      out_valid_ff  <= 1'b0;
      clamped_ff    <= 1'b0;
      out_status_ff <= 4'h0;
    end else begin
      out_valid_ff  <= v3_ff;
      out_status_ff <= {clamped_ff, corr_ff, defect_ff, ov_ff}; // RQ15
      if (v3_ff) begin
        out_value_ff <= nxt_out;
        clamped_ff   <= nxt_clamped;
      end
    end
  end

  // overvoltage level and memory error bookkeeping
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_ff        <= 1'b0;
      corr_ff      <= 1'b0;
      corr_line_ff <= 4'h0;
      defect_ff    <= 1'b0;
    end else begin
      ov_ff <= ov_detect; // RQ16
      if (mem_err_valid && !corr_ff) begin
        corr_ff      <= 1'b1; // RQ17
        corr_line_ff <= mem_err_line;
      end else if (mem_err_valid) begin
        defect_ff <= 1'b1; // RQ17 RQ18
      end
    end
  end

  // open-drain stage off during overvoltage or after a defect
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_oe_n_ff <= 1'b1;
    end else begin
      drv_oe_n_ff <= ov_ff | defect_ff; // RQ16 RQ18
    end
  end

  // sticky interrupt status; a new event beats a same-cycle clear
  assign nxt_ev[hdgo_pkg::EV_SAMPLE] = v3_ff;
  assign nxt_ev[hdgo_pkg::EV_OVER]   = ov_detect & ~ov_ff;
  assign nxt_ev[hdgo_pkg::EV_CORR]   = mem_err_valid & ~corr_ff;
  assign nxt_ev[hdgo_pkg::EV_DEFECT] = mem_err_valid & corr_ff & ~defect_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= 4'h0;
      irq_ff      <= 1'b0;
    end else begin
      if (wr && paddr == hdgo_pkg::OFF_IRQ_CLR) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | nxt_ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | nxt_ev;
      end
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // checks on the conditioning path
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_first_err;
    mem_err_valid && !corr_ff;
  endsequence

  sequence s_second_err;
    mem_err_valid && corr_ff;
  endsequence

  AST_RANGE_FOLD: assert property ( // RQ2
    range_ff == hdgo_pkg::RANGE_UNUSED |=> adc_range_ff == 2'h1)
    else $error("unused range code not folded to mid");

  AST_TICK_GAP: assert property ( // RQ8
    tick_ff |=> !tick_ff [*8])
    else $error("update ticks too close");

  AST_BYPASS: assert property ( // RQ6
    tick_ff && filt_sel_ff == hdgo_pkg::FILTER_OFF
    |=> filt == $past(adc_sample))
    else $error("bypass did not pass sample through");

  AST_GAIN_MUL: assert property ( // RQ4
    v1_ff |=> prod_ff == 20'((32'($past(filt)) * 32'($past(gain_s))) >>> 12))
    else $error("gain product wrong");

  AST_LIMIT_LOW: assert property ( // RQ19
    v2_ff && sum < 0 |=> lim_ff == 16'h0)
    else $error("negative sum not limited to zero");

  AST_FLOOR: assert property ( // RQ9
    v3_ff && floor_ff != 6'h0 && ceil_ff == 6'h3f
    |=> out_value_ff >= {$past(floor_ff), 10'h000})
    else $error("output below floor limit");

  AST_CEIL_WINS: assert property ( // RQ12
    v3_ff && ceil_ff != 6'h3f
    |=> out_value_ff <= {$past(ceil_ff), 10'h3ff})
    else $error("output above ceiling limit");

  AST_OV_OFF: assert property ( // RQ16
    ov_detect |-> ##2 drv_oe_n_ff && out_status_ff[0])
    else $error("overvoltage did not switch driver off");

  AST_CORR: assert property ( // RQ17
    s_first_err ##1 !mem_err_valid |-> corr_ff && !defect_ff)
    else $error("single error not treated as corrected");

  AST_DEFECT: assert property ( // RQ18
    s_second_err |=> defect_ff ##1 drv_oe_n_ff [*8])
    else $error("defect did not keep driver off");
endmodule
`default_nettype wire

// >>> bench/hdgo_hall_model.sv
// hall converter model feeding samples to the conditioning path
`timescale 1ns/1ps
`default_nettype none
module hdgo_hall_model (
  // clock
  input  wire logic        core_clk,
  // field level asked for by the bench
  input  wire logic [15:0] field,
  // converter output
  output logic      [15:0] adc_sample
);
  // conversion result changes only just after a clock edge
  always @(posedge core_clk) begin
    adc_sample <= field;
  end
endmodule
`default_nettype wire

// >>> bench/hall_dsp_gain_offset_clamp_bench.sv
// self-checking bench for the hall conditioning path
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module hall_dsp_gain_offset_clamp_bench;
  logic        core_clk;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] field = 16'h0000;
  logic        ov_detect = 1'b0;
  logic        mem_err_valid = 1'b0;
  logic [3:0]  mem_err_line = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  adc_range;
  logic [15:0] adc_sample;
  logic [15:0] out_value;
  logic        out_valid;
  logic [3:0]  out_status;
  logic        drv_oe_n;
  logic        irq;
  logic        last_err;
  logic [31:0] rd_q[$];
  logic [15:0] out_q[$];
  logic [31:0] re;
  logic [15:0] oe;
  logic [15:0] rx;
  logic [14:0] rg;
  logic [14:0] ro;
  logic [5:0]  rf;
  logic [5:0]  rc;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          last_v = -1;

  hdgo_core uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata), .pready_ff(pready), .pslverr_ff(pslverr),
    .adc_sample(adc_sample), .adc_range_ff(adc_range),
    .ov_detect(ov_detect), .mem_err_valid(mem_err_valid),
    .mem_err_line(mem_err_line), .out_value_ff(out_value),
    .out_valid_ff(out_valid), .out_status_ff(out_status),
    .drv_oe_n_ff(drv_oe_n), .irq_ff(irq));
  hdgo_hall_model u_hall (.core_clk(core_clk), .field(field),
    .adc_sample(adc_sample));

  // 40 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // look at ready where it is settled, mid-cycle
    do begin
      @(negedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    last_err = pslverr;
    // the edge with ready high completes the transfer
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read with the expected word noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // read data taken while it stands in the access cycle
  always @(negedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
    begin
      re = rd_q.pop_front();
      `CHK("prdata", re, prdata)
    end
  end

  // result watcher: spacing of results and value against oldest note
  always @(negedge core_clk) begin
    cyc++;
    if (out_valid === 1'b1) begin
      if (last_v >= 0) `CHK("period", 2500, cyc - last_v)
      last_v = cyc;
      if (out_q.size() > 0) begin
        oe = out_q.pop_front();
        `CHK("out_value", oe, out_value)
      end
    end
  end

  // expected result worked out from the decoding rules
  function automatic logic [15:0] calc(input logic [15:0] x,
    input logic [14:0] g, o, input logic [5:0] f, c);
    longint s;
    s = (longint'($signed(x)) * (longint'(g) - 16384)) >>> 12;
    s = s + longint'(o) - 16384;
    if (s < 0) s = 0;
    if (s > 65535) s = 65535;
    if (f != 6'h00 && s < f * 1024) s = f * 1024;
    if (c != 6'h3f && s > (c + 1) * 1024 - 1) s = (c + 1) * 1024 - 1;
    return s[15:0];
  endfunction

  // wait past the next result pulse
  task automatic wres();
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (out_valid !== 1'b1 && n < 6000);
    if (out_valid !== 1'b1) error_cnt++;
    @(posedge core_clk);
  endtask

  // program one setting, drop the mixed pass, check the next result
  task automatic run(input logic [15:0] x, input logic [14:0] g, o,
                     input logic [5:0] f, c);
    logic ce;
    field <= x;
    apb(1'b1, hdgo_pkg::OFF_GAIN, {17'h0, g});
    apb(1'b1, hdgo_pkg::OFF_OFFSET, {17'h0, o});
    apb(1'b1, hdgo_pkg::OFF_CLAMP, {18'h0, c, 2'h0, f});
    wres();
    out_q.push_back(calc(x, g, o, f, c));
    wres();
    // clamp flag of that result shows in the status nibble a cycle later
    @(posedge core_clk);
    ce = (calc(x, g, o, f, c) != calc(x, g, o, 6'h00, 6'h3f));
    `CHK("clamped", ce, out_status[3])
  endtask

  // closing verdict
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    void'($urandom(85));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(hdgo_pkg::OFF_RANGE, 32'h1);
    rd(hdgo_pkg::OFF_GAIN, 32'h5000);
    rd(hdgo_pkg::OFF_FILTER, 32'h7);
    rd(hdgo_pkg::OFF_CLAMP, 32'h3f00);
    rd(8'h40, 32'h0);
    `CHK("pslverr", 1'b1, last_err)
    // every range code, the unused one folds onto the middle range
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, hdgo_pkg::OFF_RANGE, r);
      repeat (2) @(posedge core_clk);
      `CHK("range", (r == 2) ? 2'h1 : 2'(r), adc_range)
    end
    run(16'd1000, 15'h5000, 15'h5388, 6'd0, 6'd63);
    run(16'hf448, 15'h0000, 15'h4000, 6'd20, 6'd63);
    run(16'h7fff, 15'h7fff, 15'h7fff, 6'd0, 6'd50);
    run(16'd100, 15'h5000, 15'h0000, 6'd0, 6'd63);
    run(16'd1000, 15'h5000, 15'h4000, 6'd40, 6'd10);
    // random settings with floor kept below ceiling
    for (int i = 0; i < 3; i++) begin
      rx = 16'($urandom);
      rg = 15'($urandom);
      ro = 15'($urandom);
      rf = 6'($urandom_range(0, 31));
      rc = 6'($urandom_range(32, 63));
      run(rx, rg, ro, rf, rc);
    end
    // steady input: every filter setting keeps the same value
    run(16'd5000, 15'h5000, 15'h4000, 6'd0, 6'd63);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, hdgo_pkg::OFF_FILTER, 32'(k));
      wres();
      out_q.push_back(16'd5000);
    end
    wres();
    rd(hdgo_pkg::OFF_RESULT, 32'd5000);
    // overvoltage masked, then enabled, then cleared
    apb(1'b1, hdgo_pkg::OFF_IRQ_CLR, 32'hf);
    ov_detect <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK("drv_off", 1'b1, drv_oe_n)
    `CHK("ov_flag", 1'b1, out_status[0])
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, hdgo_pkg::OFF_IRQ_EN, 32'h2);
    repeat (2) @(posedge core_clk);
    `CHK("irq_on", 1'b1, irq)
    ov_detect <= 1'b0;
    apb(1'b1, hdgo_pkg::OFF_IRQ_CLR, 32'h2);
    repeat (2) @(posedge core_clk);
    `CHK("irq_off", 1'b0, irq)
    `CHK("drv_on", 1'b0, drv_oe_n)
    // first memory error corrected, second one is a defect
    apb(1'b1, hdgo_pkg::OFF_IRQ_EN, 32'hc);
    for (int m = 0; m < 2; m++) begin
      mem_err_line <= 4'($urandom);
      mem_err_valid <= 1'b1;
      @(posedge core_clk);
      mem_err_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK("mem_flag", 1'b1, out_status[2 - m])
      `CHK("drv_mem", 1'(m), drv_oe_n)
      `CHK("irq_mem", 1'b1, irq)
    end
    repeat (2600) @(posedge core_clk);
    `CHK("drv_kept", 1'b1, drv_oe_n)
    rd(hdgo_pkg::OFF_STATUS, 32'h36);
    rd(hdgo_pkg::OFF_IRQ_ST, 32'hd);
    summarize();
  end
endmodule
`default_nettype wire
